// ---- hdl/dps_mem.sv ----
`default_nettype none
module dps_mem #(
	parameter int unsigned WIDTH = 16,
	parameter int unsigned DEPTH = 1050,
	parameter int unsigned AW = 11
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic we_in,
	input wire logic [AW-1:0] waddr_in,
	input wire logic [WIDTH-1:0] wdata_in,
	input wire logic [AW-1:0] raddr_in,
	output logic [WIDTH-1:0] rdata_out
);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [WIDTH-1:0] rdata_q;

	////////////////////////////////////////////////////////////////////////
	// array has no reset; the owner clears it by a sweep after reset
	always_ff @(posedge clk_in)
	begin
		if (we_in)
			mem_q[waddr_in] <= wdata_in;
	end

	// registered read, old data on a same-address write
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			rdata_q <= '0;
		else
			rdata_q <= mem_q[raddr_in];
	end

	assign rdata_out = rdata_q;
endmodule : dps_mem
`default_nettype wire

// ---- hdl/dps_store.sv ----
// Behaviour
// - parameters sit in 21 menus of up to 50 parameters each
// - menu zero is reachable in every mode and security state
// - all other menus need standard security unlocked
// - menus 16 and 20 exist only with their option module fitted
// - menu 15 exists only in regenerative mode
// - regenerative mode removes menus 1 to 5 and motor parameters of 6
// - menu 13 exists in all modes except regenerative
// - menu 20 needs the coprocessor module, menu 16 a small module
// - read-only parameters show drive state, never a user value
// - bit parameters hold only 0 or 1
// - non-bit parameters are limited to their own numeric range
// - text parameters are written by their numeric code
// - ordinary writes take effect at once
// - reset-activated writes wait pending until a drive reset
// - values are volatile unless stored to nonvolatile memory
// - save-at-power-down parameters are stored when power fails
// - programmable inputs and functions may drive parameters
// - protected parameters refuse programmable routing
// - menu 17 exists in all four modes, behind security
// - each parameter is addressed by menu and parameter index
`default_nettype none
module dps_store (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [1:0] mode_in,
	input wire logic sec_unlocked_in,
	input wire logic small_opt_fitted_in,
	input wire logic application_coprocessor_module_fitted_in,
	input wire logic req_valid_in,
	output logic req_ready_out,
	input wire logic req_write_in,
	input wire dps_pkg::dps_src_e req_src_in,
	input wire logic [dps_pkg::MENU_W-1:0] req_menu_in,
	input wire logic [dps_pkg::PARAM_W-1:0] req_param_in,
	input wire logic [dps_pkg::VAL_W-1:0] req_wdata_in,
	input wire logic attr_read_only_in,
	input wire logic attr_bit_in,
	input wire logic attr_bipolar_in,
	input wire logic [dps_pkg::VAL_W-1:0] attr_max_in,
	input wire logic attr_reset_act_in,
	input wire logic attr_save_pd_in,
	input wire logic attr_protected_in,
	input wire logic attr_motor_ctl_in,
	input wire logic drive_reset_in,
	input wire logic power_fail_in,
	input wire logic nv_store_in,
	output logic rsp_valid_out,
	output dps_pkg::dps_err_e rsp_err_out,
	output logic [dps_pkg::VAL_W-1:0] rsp_rdata_out,
	output logic nv_valid_out,
	output logic [dps_pkg::MENU_W-1:0] nv_menu_out,
	output logic [dps_pkg::PARAM_W-1:0] nv_param_out,
	output logic [dps_pkg::VAL_W-1:0] nv_data_out,
	output logic busy_out
);
	import dps_pkg::*;

	// every check below runs on the drive clock and sleeps in reset
	default clocking dps_cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	function automatic logic [ADDR_W-1:0] lin_addr(
		input logic [MENU_W-1:0] m, input logic [PARAM_W-1:0] p);
		lin_addr = ADDR_W'(32'(m) * PARAMS_PER_MENU + 32'(p));
	endfunction : lin_addr

	////////////////////////////////////////////////////////////////////////
	// mode, security and module-fitted straps come from outside the domain
	logic [4:0] cfg_meta_q;
	logic [4:0] cfg_sync_q;

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			cfg_meta_q <= '0;
			cfg_sync_q <= '0;
		end
		else
		begin
			cfg_meta_q <= {application_coprocessor_module_fitted_in,
				small_opt_fitted_in, sec_unlocked_in, mode_in};
			cfg_sync_q <= cfg_meta_q;
		end
	end

	wire dps_mode_e mode_s = dps_mode_e'(cfg_sync_q[1:0]);
	wire logic unlocked_s = cfg_sync_q[2];
	wire logic small_s = cfg_sync_q[3];
	wire logic app_s = cfg_sync_q[4];
	wire logic regen = (mode_s == MODE_REGEN);

	////////////////////////////////////////////////////////////////////////
	// presence of the addressed menu; menu 17 has no removal term
	wire logic in_range = (req_menu_in <= LAST_MENU) &&
		(req_param_in <= LAST_PARAM);
	wire logic gone_motor = regen && (req_menu_in >= MENU_MOTOR_FIRST) &&
		(req_menu_in <= MENU_MOTOR_LAST);
	wire logic gone_seq = regen && attr_motor_ctl_in &&
		(req_menu_in == MENU_SEQUENCER);
	wire logic gone_bridge = !regen &&
		(req_menu_in == MENU_REGEN_BRIDGE);
	wire logic gone_pos = regen && (req_menu_in == MENU_POSITION);
	wire logic gone_small = !small_s &&
		(req_menu_in == MENU_SMALL_OPT);
	wire logic gone_app = !app_s && (req_menu_in == MENU_APP);
	wire logic present = in_range && !(gone_motor || gone_seq ||
		gone_bridge || gone_pos || gone_small || gone_app);
	// security only gates the keypad and serial host, not drive logic
	wire logic locked = (req_src_in == SRC_USER) && !unlocked_s &&
		(req_menu_in != MENU_GENERAL);

	////////////////////////////////////////////////////////////////////////
	// value checks; text parameters arrive as their numeric code
	wire logic signed [VAL_W:0] wv = {req_wdata_in[VAL_W-1], req_wdata_in};
	wire logic signed [VAL_W:0] smax = {1'b0, attr_max_in};
	wire logic bit_ok = (req_wdata_in <= 16'h0001);
	wire logic bi_ok = (wv <= smax) && (wv >= -smax);
	wire logic uni_ok = (req_wdata_in <= attr_max_in);
	wire logic val_ok = attr_bit_in ? bit_ok :
		(attr_bipolar_in ? bi_ok : uni_ok);
	// drive logic is the only writer of read-only state
	wire logic ro_bad = (req_src_in == SRC_DRIVE) ? !attr_read_only_in :
		attr_read_only_in;
	// routed inputs may drive bits or values unless protected
	wire logic prot_bad = (req_src_in == SRC_ROUTE) &&
		attr_protected_in;

	dps_err_e req_err;
	always_comb
	begin
		if (!present)
			req_err = ERR_ABSENT;
		else if (locked)
			req_err = ERR_LOCKED;
		else if (!req_write_in)
			req_err = ERR_NONE;
		else if (ro_bad)
			req_err = ERR_READ_ONLY;
		else if (prot_bad)
			req_err = ERR_PROTECTED;
		else if (!val_ok)
			req_err = ERR_RANGE;
		else
			req_err = ERR_NONE;
	end

	////////////////////////////////////////////////////////////////////////
	// sweep engine state and sticky triggers
	dps_state_e state_q, state_d;
	dps_op_e op_q, op_d;
	logic [MENU_W-1:0] swp_menu_q, swp_menu_d;
	logic [PARAM_W-1:0] swp_param_q, swp_param_d;
	logic pf_q, store_q, dreset_q;
	logic [ACT_W-1:0] act_rd;
	logic [PND_W-1:0] pnd_rd;

	wire logic idle = (state_q == ST_IDLE);
	wire logic any_trig = pf_q || store_q || dreset_q;
	wire logic take_sweep = idle && any_trig;
	wire logic take_pf = take_sweep && pf_q;
	wire logic take_store = take_sweep && !pf_q && store_q;
	wire logic take_reset = take_sweep && !pf_q && !store_q;
	wire logic swp_last = (swp_menu_q == LAST_MENU) &&
		(swp_param_q == LAST_PARAM);
	wire logic [ADDR_W-1:0] swp_addr = lin_addr(swp_menu_q, swp_param_q);
	wire logic [ADDR_W-1:0] req_addr =
		lin_addr(req_menu_in, req_param_in);

	// requests wait while a sweep owns the stores
	assign req_ready_out = idle && !any_trig;
	assign busy_out = !idle;
	wire logic accept = req_valid_in && req_ready_out;
	wire logic wr_ok = accept && req_write_in && (req_err == ERR_NONE);
	wire logic flag_set = pnd_rd[FLAG_BIT];

	////////////////////////////////////////////////////////////////////////
	// store port steering: requests when idle, the sweep otherwise
	wire logic swp_move = (state_q == ST_WR) && ((op_q == OP_CLEAR) ||
		((op_q == OP_APPLY) && flag_set));
	wire logic act_we = idle ? (wr_ok && !attr_reset_act_in) :
		swp_move;
	wire logic pnd_we = idle ? (wr_ok && attr_reset_act_in) :
		swp_move;
	wire logic [ADDR_W-1:0] mem_addr = idle ? req_addr : swp_addr;
	wire logic [ACT_W-1:0] act_wdata = idle ?
		{attr_save_pd_in, req_wdata_in} :
		((op_q == OP_CLEAR) ? {1'b0, VAL_RESET} : pnd_rd[ACT_W-1:0]);
	wire logic [PND_W-1:0] pnd_wdata = idle ?
		{1'b1, attr_save_pd_in, req_wdata_in} : {2'b00, VAL_RESET};

	dps_mem #(.WIDTH(ACT_W), .DEPTH(DEPTH), .AW(ADDR_W)) u_active (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.we_in(act_we),
		.waddr_in(mem_addr),
		.wdata_in(act_wdata),
		.raddr_in(mem_addr),
		.rdata_out(act_rd)
	);

	dps_mem #(.WIDTH(PND_W), .DEPTH(DEPTH), .AW(ADDR_W)) u_pending (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.we_in(pnd_we),
		.waddr_in(mem_addr),
		.wdata_in(pnd_wdata),
		.raddr_in(mem_addr),
		.rdata_out(pnd_rd)
	);

	////////////////////////////////////////////////////////////////////////
	// sweep sequencing: one read cycle and one write cycle per parameter
	always_comb
	begin
		state_d = state_q;
		op_d = op_q;
		swp_menu_d = swp_menu_q;
		swp_param_d = swp_param_q;
		case (state_q)
			ST_IDLE:
			begin
				if (take_sweep)
				begin
					state_d = ST_RD;
					swp_menu_d = '0;
					swp_param_d = '0;
					if (take_pf)
						op_d = OP_SAVE_PD;
					else if (take_store)
						op_d = OP_SAVE_ALL;
					else
						op_d = OP_APPLY;
				end
			end
			ST_RD:
				state_d = ST_WR;
			ST_WR:
			begin
				if (swp_last)
					state_d = ST_IDLE;
				else
				begin
					state_d = ST_RD;
					if (swp_param_q == LAST_PARAM)
					begin
						swp_param_d = '0;
						swp_menu_d = swp_menu_q + 5'h01;
					end
					else
						swp_param_d = swp_param_q + 6'h01;
				end
			end
			default:
				state_d = ST_IDLE;
		endcase
	end

	// reset starts a clearing sweep so stored values are defined
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			state_q <= ST_RD;
			op_q <= OP_CLEAR;
			swp_menu_q <= '0;
			swp_param_q <= '0;
		end
		else
		begin
			state_q <= state_d;
			op_q <= op_d;
			swp_menu_q <= swp_menu_d;
			swp_param_q <= swp_param_d;
		end
	end

	// triggers are sticky; a new pulse wins over the take that clears it
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			pf_q <= 1'b0;
			store_q <= 1'b0;
			dreset_q <= 1'b0;
		end
		else
		begin
			pf_q <= power_fail_in || (pf_q && !take_pf);
			store_q <= nv_store_in || (store_q && !take_store);
			dreset_q <= drive_reset_in || (dreset_q && !take_reset);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// answers one cycle after acceptance, nonvolatile stream from sweeps
	logic rsp_valid_q, rsp_rd_q, nv_valid_q;
	dps_err_e rsp_err_q;
	logic [MENU_W-1:0] nv_menu_q;
	logic [PARAM_W-1:0] nv_param_q;
	logic [VAL_W-1:0] nv_data_q;
	wire logic nv_emit = (state_q == ST_WR) && ((op_q == OP_SAVE_ALL) ||
		((op_q == OP_SAVE_PD) && act_rd[SAVE_BIT]));

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			rsp_valid_q <= 1'b0;
			rsp_rd_q <= 1'b0;
			rsp_err_q <= ERR_NONE;
			nv_valid_q <= 1'b0;
			nv_menu_q <= '0;
			nv_param_q <= '0;
			nv_data_q <= '0;
		end
		else
		begin
			rsp_valid_q <= accept;
			rsp_rd_q <= accept && !req_write_in && (req_err == ERR_NONE);
			rsp_err_q <= accept ? req_err : ERR_NONE;
			nv_valid_q <= nv_emit;
			nv_menu_q <= swp_menu_q;
			nv_param_q <= swp_param_q;
			nv_data_q <= act_rd[VAL_W-1:0];
		end
	end

	assign rsp_valid_out = rsp_valid_q;
	assign rsp_err_out = rsp_err_q;
	assign rsp_rdata_out = rsp_rd_q ? act_rd[VAL_W-1:0] : '0;
	assign nv_valid_out = nv_valid_q;
	assign nv_menu_out = nv_menu_q;
	assign nv_param_out = nv_param_q;
	assign nv_data_out = nv_data_q;

	////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_take_apply;
		take_reset;
	endsequence
	sequence s_sweep_start;
		(state_q == ST_RD) && (swp_addr == '0) ##1 (state_q == ST_WR);
	endsequence

	chk_menu_zero_open: assert property (
		accept && (req_menu_in == MENU_GENERAL) && !req_write_in &&
		(req_param_in <= LAST_PARAM) |=> rsp_err_q == ERR_NONE)
		else $error("menu zero read refused");
	chk_security_lock: assert property (
		accept && (req_src_in == SRC_USER) && !unlocked_s &&
		(req_menu_in == MENU_LARGE_OPT) && (req_param_in <= LAST_PARAM)
		|=> rsp_valid_q && (rsp_err_q == ERR_LOCKED))
		else $error("locked menu reached");
	chk_regen_bridge: assert property (
		accept && !regen && (req_menu_in == MENU_REGEN_BRIDGE)
		|=> rsp_err_q == ERR_ABSENT)
		else $error("menu 15 present outside regen");
	chk_regen_motor: assert property (
		accept && regen && (req_menu_in >= MENU_MOTOR_FIRST) &&
		(req_menu_in <= MENU_MOTOR_LAST) |=> rsp_err_q == ERR_ABSENT)
		else $error("motor menu present in regen");
	chk_read_only_keep: assert property (
		accept && req_write_in && attr_read_only_in &&
		(req_src_in != SRC_DRIVE) |-> !act_we && !pnd_we ##1
		rsp_err_q != ERR_NONE)
		else $error("read-only parameter took a user value");
	chk_bit_values: assert property (
		accept && req_write_in && attr_bit_in && (req_wdata_in > 16'h0001)
		|=> rsp_err_q != ERR_NONE)
		else $error("bit parameter took a value above one");
	chk_protected_route: assert property (
		accept && req_write_in && attr_protected_in &&
		(req_src_in == SRC_ROUTE) |-> !act_we ##1
		(rsp_err_q == ERR_PROTECTED || rsp_err_q == ERR_ABSENT ||
		rsp_err_q == ERR_READ_ONLY))
		else $error("protected parameter routed");
	chk_refused_quiet: assert property (
		rsp_valid_q && (rsp_err_q != ERR_NONE) |->
		!$past(act_we) && !$past(pnd_we))
		else $error("refused request changed a store");
	chk_reset_defer: assert property (
		accept && req_write_in && attr_reset_act_in |-> !act_we)
		else $error("reset-activated write applied at once");
	chk_apply_start: assert property (
		s_take_apply |=> s_sweep_start)
		else $error("drive reset did not start apply sweep");
endmodule : dps_store
`default_nettype wire

// ---- include/dps_pkg.sv ----
`default_nettype none
package dps_pkg;
	// store geometry
	localparam int unsigned NUM_MENUS = 21;
	localparam int unsigned PARAMS_PER_MENU = 50;
	localparam int unsigned MENU_W = 5;
	localparam int unsigned PARAM_W = 6;
	localparam int unsigned ADDR_W = 11;
	localparam int unsigned DEPTH = NUM_MENUS * PARAMS_PER_MENU;
	localparam int unsigned VAL_W = 16;
	localparam logic [MENU_W-1:0] LAST_MENU = MENU_W'(NUM_MENUS - 1);
	localparam logic [PARAM_W-1:0] LAST_PARAM = PARAM_W'(PARAMS_PER_MENU - 1);

	// named menus; all but 0 and 17 have a presence that depends on mode or fitted modules
	localparam logic [MENU_W-1:0] MENU_GENERAL = 5'h00;
	localparam logic [MENU_W-1:0] MENU_MOTOR_FIRST = 5'h01;
	localparam logic [MENU_W-1:0] MENU_MOTOR_LAST = 5'h05;
	localparam logic [MENU_W-1:0] MENU_SEQUENCER = 5'h06;
	localparam logic [MENU_W-1:0] MENU_POSITION = 5'h0d;
	localparam logic [MENU_W-1:0] MENU_REGEN_BRIDGE = 5'h0f;
	localparam logic [MENU_W-1:0] MENU_SMALL_OPT = 5'h10;
	localparam logic [MENU_W-1:0] MENU_LARGE_OPT = 5'h11;
	localparam logic [MENU_W-1:0] MENU_APP = 5'h14;

	// stored word layouts: active {save, value}, pending {flag, save, value}
	localparam int unsigned ACT_W = VAL_W + 1;
	localparam int unsigned PND_W = VAL_W + 2;
	localparam int unsigned SAVE_BIT = VAL_W;
	localparam int unsigned FLAG_BIT = VAL_W + 1;
	localparam logic [VAL_W-1:0] VAL_RESET = 16'h0000;

	typedef enum logic [1:0] {MODE_OPEN, MODE_VECTOR, MODE_SERVO, MODE_REGEN}
		dps_mode_e;
	typedef enum logic [1:0] {SRC_USER, SRC_ROUTE, SRC_DRIVE} dps_src_e;
	typedef enum logic [2:0] {ERR_NONE, ERR_ABSENT, ERR_LOCKED, ERR_READ_ONLY,
		ERR_RANGE, ERR_PROTECTED} dps_err_e;
	typedef enum logic [1:0] {ST_IDLE, ST_RD, ST_WR} dps_state_e;
	typedef enum logic [1:0] {OP_CLEAR, OP_APPLY, OP_SAVE_ALL, OP_SAVE_PD}
		dps_op_e;
endpackage : dps_pkg
`default_nettype wire

// ---- sim/dps_host.sv ----
`default_nettype none
// keypad or serial host: one request at a time, held until accepted
module dps_host (
	input wire logic clk_in,
	input wire logic req_ready_in,
	input wire logic rsp_valid_in,
	input wire dps_pkg::dps_err_e rsp_err_in,
	input wire logic [dps_pkg::VAL_W-1:0] rsp_rdata_in,
	output logic req_valid_out,
	output logic req_write_out,
	output var dps_pkg::dps_src_e req_src_out,
	output logic [dps_pkg::MENU_W-1:0] req_menu_out,
	output logic [dps_pkg::PARAM_W-1:0] req_param_out,
	output logic [dps_pkg::VAL_W-1:0] req_wdata_out
);
	timeunit 1ns;
	timeprecision 1ps;
	import dps_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// idle request lines at time zero
	initial
	begin
		req_valid_out = 1'h0;
		req_write_out = 1'h0;
		req_src_out = SRC_USER;
		req_menu_out = 5'h00;
		req_param_out = 6'h00;
		req_wdata_out = 16'h0000;
	end

	////////////////////////////////////////////////////////////////////////
	// one transfer; an answer that never comes leaves x in err and data
	task automatic xfer(input logic wr, input dps_src_e src,
		input logic [MENU_W-1:0] m, input logic [PARAM_W-1:0] p,
		input logic [VAL_W-1:0] wd, output logic [2:0] err,
		output logic [VAL_W-1:0] rd);
		int n;
		err = 3'hx;
		rd = 16'hxxxx;
		@(negedge clk_in);
		req_valid_out = 1'h1;
		req_write_out = wr;
		req_src_out = src;
		req_menu_out = m;
		req_param_out = p;
		req_wdata_out = wd;
		n = 0;
		// ready only changes at a rising edge, so its value now holds there
		while (req_ready_in !== 1'h1 && n < 3000)
		begin
			@(negedge clk_in);
			n++;
		end
		@(posedge clk_in);
		@(negedge clk_in);
		// released fields stop showing the old request
		req_valid_out = 1'h0;
		req_write_out = ~wr;
		req_menu_out = ~m;
		req_param_out = ~p;
		req_wdata_out = ~wd;
		n = 0;
		while (rsp_valid_in !== 1'h1 && n < 3)
		begin
			@(negedge clk_in);
			n++;
		end
		if (rsp_valid_in === 1'h1)
		begin
			err = rsp_err_in;
			rd = rsp_rdata_in;
		end
	endtask : xfer
endmodule : dps_host
`default_nettype wire

// ---- sim/drive_parameter_store_tb_top.sv ----
`default_nettype none
module drive_parameter_store_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import dps_pkg::*;

	localparam logic [6:0] A_RO = 7'h40;
	localparam logic [6:0] A_BIT = 7'h20;
	localparam logic [6:0] A_BIP = 7'h10;
	localparam logic [6:0] A_RA = 7'h08;
	localparam logic [6:0] A_SPD = 7'h04;
	localparam logic [6:0] A_PROT = 7'h02;
	localparam int LIMIT = 20000;

	typedef struct {
		dps_mode_e mode;
		logic [2:0] cfg; // unlocked, small module, coprocessor
		logic [4:0] menu;
		logic [5:0] param;
		logic mot;
		dps_err_e err;
	} dps_row_s;

	logic clk_in = 1'h0;
	logic rst_n_in = 1'h0;
	dps_mode_e mode = MODE_OPEN;
	logic sec = 1'h0, sm = 1'h0, ap = 1'h0;
	logic a_ro, a_bit, a_bip, a_ra, a_spd, a_prot, a_mot;
	logic [15:0] a_max;
	logic drive_reset = 1'h0, power_fail = 1'h0, nv_store = 1'h0;
	logic req_valid, req_ready, req_write, rsp_valid, nv_valid, busy;
	dps_src_e req_src;
	dps_err_e rsp_err;
	logic [4:0] req_menu, nv_menu;
	logic [5:0] req_param, nv_param;
	logic [15:0] req_wdata, rsp_rdata, nv_data, got_rd, nv_d71, nv_d76;
	logic [2:0] got_err;
	int checked = 0, error_cnt = 0, cyc = 0, nv_bad = 0, nv_last = -1;
	int nv_cnt = 0;

	// presence and security, read by the keypad
	dps_row_s rows [20] = '{
		'{MODE_OPEN, 3'h0, 5'h00, 6'h00, 1'h0, ERR_NONE},
		'{MODE_REGEN, 3'h0, 5'h00, 6'h03, 1'h0, ERR_NONE},
		'{MODE_OPEN, 3'h0, 5'h07, 6'h00, 1'h0, ERR_LOCKED},
		'{MODE_SERVO, 3'h3, 5'h11, 6'h00, 1'h0, ERR_LOCKED},
		'{MODE_OPEN, 3'h4, 5'h10, 6'h00, 1'h0, ERR_ABSENT},
		'{MODE_OPEN, 3'h6, 5'h10, 6'h00, 1'h0, ERR_NONE},
		'{MODE_SERVO, 3'h6, 5'h14, 6'h00, 1'h0, ERR_ABSENT},
		'{MODE_SERVO, 3'h5, 5'h14, 6'h00, 1'h0, ERR_NONE},
		'{MODE_VECTOR, 3'h4, 5'h0f, 6'h00, 1'h0, ERR_ABSENT},
		'{MODE_REGEN, 3'h4, 5'h0f, 6'h00, 1'h0, ERR_NONE},
		'{MODE_REGEN, 3'h4, 5'h01, 6'h00, 1'h0, ERR_ABSENT},
		'{MODE_REGEN, 3'h4, 5'h05, 6'h00, 1'h0, ERR_ABSENT},
		'{MODE_REGEN, 3'h4, 5'h06, 6'h00, 1'h1, ERR_ABSENT},
		'{MODE_REGEN, 3'h4, 5'h06, 6'h00, 1'h0, ERR_NONE},
		'{MODE_OPEN, 3'h4, 5'h0d, 6'h00, 1'h0, ERR_NONE},
		'{MODE_REGEN, 3'h4, 5'h0d, 6'h00, 1'h0, ERR_ABSENT},
		'{MODE_REGEN, 3'h4, 5'h11, 6'h00, 1'h0, ERR_NONE},
		'{MODE_VECTOR, 3'h4, 5'h15, 6'h00, 1'h0, ERR_ABSENT},
		'{MODE_VECTOR, 3'h4, 5'h13, 6'h32, 1'h0, ERR_ABSENT},
		'{MODE_VECTOR, 3'h4, 5'h13, 6'h31, 1'h0, ERR_NONE}
	};

	////////////////////////////////////////////////////////////////////////
	dps_store i_dps_store (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.mode_in(mode), .sec_unlocked_in(sec), .small_opt_fitted_in(sm),
		.application_coprocessor_module_fitted_in(ap),
		.req_valid_in(req_valid), .req_ready_out(req_ready),
		.req_write_in(req_write), .req_src_in(req_src),
		.req_menu_in(req_menu), .req_param_in(req_param),
		.req_wdata_in(req_wdata), .attr_read_only_in(a_ro),
		.attr_bit_in(a_bit), .attr_bipolar_in(a_bip), .attr_max_in(a_max),
		.attr_reset_act_in(a_ra), .attr_save_pd_in(a_spd),
		.attr_protected_in(a_prot), .attr_motor_ctl_in(a_mot),
		.drive_reset_in(drive_reset), .power_fail_in(power_fail),
		.nv_store_in(nv_store), .rsp_valid_out(rsp_valid),
		.rsp_err_out(rsp_err), .rsp_rdata_out(rsp_rdata),
		.nv_valid_out(nv_valid), .nv_menu_out(nv_menu),
		.nv_param_out(nv_param), .nv_data_out(nv_data), .busy_out(busy));

	dps_host i_dps_host (.clk_in(clk_in), .req_ready_in(req_ready),
		.rsp_valid_in(rsp_valid), .rsp_err_in(rsp_err),
		.rsp_rdata_in(rsp_rdata), .req_valid_out(req_valid),
		.req_write_out(req_write), .req_src_out(req_src),
		.req_menu_out(req_menu), .req_param_out(req_param),
		.req_wdata_out(req_wdata));

	////////////////////////////////////////////////////////////////////////
	// clock, hang limit and the store sweep monitor
	always #2.5 clk_in = ~clk_in;

	always @(posedge clk_in)
	begin
		cyc++;
		if (cyc == LIMIT)
		begin
			error_cnt++;
			print_verdict();
		end
	end

	// sampled mid-cycle so the registered words have settled
	always @(negedge clk_in)
		if (nv_valid === 1'h1)
		begin
			nv_cnt++;
			if (nv_menu === 5'h07 && nv_param === 6'h01)
				nv_d71 = nv_data;
			if (nv_menu === 5'h07 && nv_param === 6'h06)
				nv_d76 = nv_data;
			if (int'({nv_menu, nv_param}) <= nv_last)
				nv_bad++;
			nv_last = int'({nv_menu, nv_param});
		end

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string name, input logic [15:0] seen,
		input logic [15:0] exp);
		checked++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic chk_err(input dps_err_e e);
		chk("rsp_err", {13'h0000, got_err}, {13'h0000, e});
	endtask : chk_err

	task automatic acc(input logic wr, input dps_src_e s, input logic [4:0] m,
		input logic [5:0] p, input logic [15:0] wd);
		i_dps_host.xfer(wr, s, m, p, wd, got_err, got_rd);
	endtask : acc

	task automatic attr(input logic [6:0] f, input logic [15:0] mx);
		{a_ro, a_bit, a_bip, a_ra, a_spd, a_prot, a_mot} = f;
		a_max = mx;
	endtask : attr

	// config inputs pass a two-stage synchroniser, so allow a margin
	task automatic cfg(input dps_mode_e md, input logic [2:0] c);
		@(negedge clk_in);
		mode = md;
		{sec, sm, ap} = c;
		repeat (4) @(negedge clk_in);
	endtask : cfg

	task automatic wait_idle();
		int n;
		n = 0;
		while (busy !== 1'h0 && n < 2500)
		begin
			@(negedge clk_in);
			n++;
		end
		chk("busy_out", {15'h0000, busy}, 16'h0000);
	endtask : wait_idle

	// one-cycle trigger pulse, then the whole sweep
	task automatic trig(input int k);
		int n;
		@(negedge clk_in);
		case (k)
			0: nv_store = 1'h1;
			1: power_fail = 1'h1;
			default: drive_reset = 1'h1;
		endcase
		@(negedge clk_in);
		{nv_store, power_fail, drive_reset} = 3'h0;
		for (n = 0; n < 5 && busy !== 1'h1; n++)
			@(negedge clk_in);
		wait_idle();
	endtask : trig

	task automatic print_verdict();
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : print_verdict

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		attr(7'h00, 16'hffff);
		repeat (20) @(negedge clk_in);
		chk("busy_out", {15'h0000, busy}, 16'h0001);
		chk("rsp_valid_out", {15'h0000, rsp_valid}, 16'h0000);
		rst_n_in = 1'h1;
		wait_idle();
		foreach (rows[i])
		begin
			cfg(rows[i].mode, rows[i].cfg);
			attr({6'h00, rows[i].mot}, 16'hffff);
			acc(1'h0, SRC_USER, rows[i].menu, rows[i].param, 16'h0000);
			chk_err(rows[i].err);
		end
		cfg(MODE_OPEN, 3'h4);
		attr(7'h00, 16'hffff);
		acc(1'h1, SRC_USER, 5'h07, 6'h01, 16'h1234);
		acc(1'h1, SRC_USER, 5'h07, 6'h02, 16'h5a5a);
		acc(1'h0, SRC_USER, 5'h07, 6'h01, 16'h0000);
		chk("rdata", got_rd, 16'h1234);
		cfg(MODE_OPEN, 3'h0);
		acc(1'h1, SRC_USER, 5'h07, 6'h01, 16'h1111);
		chk_err(ERR_LOCKED);
		cfg(MODE_OPEN, 3'h4);
		acc(1'h0, SRC_USER, 5'h07, 6'h01, 16'h0000);
		chk("rdata", got_rd, 16'h1234);
		attr(A_RO, 16'hffff);
		acc(1'h1, SRC_USER, 5'h07, 6'h03, 16'h0abc);
		chk_err(ERR_READ_ONLY);
		acc(1'h1, SRC_DRIVE, 5'h07, 6'h03, 16'h0055);
		acc(1'h0, SRC_USER, 5'h07, 6'h03, 16'h0000);
		chk("rdata", got_rd, 16'h0055);
		attr(A_BIT, 16'hffff);
		acc(1'h1, SRC_USER, 5'h07, 6'h04, 16'h0002);
		chk_err(ERR_RANGE);
		acc(1'h1, SRC_USER, 5'h07, 6'h04, 16'h0001);
		chk_err(ERR_NONE);
		attr(7'h00, 16'h0064);
		acc(1'h1, SRC_USER, 5'h07, 6'h07, 16'h0065);
		chk_err(ERR_RANGE);
		acc(1'h1, SRC_USER, 5'h07, 6'h07, 16'h0064);
		chk_err(ERR_NONE);
		attr(A_BIP, 16'h0064);
		acc(1'h1, SRC_USER, 5'h07, 6'h07, 16'hff9c);
		chk_err(ERR_NONE);
		acc(1'h1, SRC_USER, 5'h07, 6'h07, 16'hff9b);
		chk_err(ERR_RANGE);
		attr(A_PROT, 16'hffff);
		acc(1'h1, SRC_ROUTE, 5'h07, 6'h08, 16'h0009);
		chk_err(ERR_PROTECTED);
		acc(1'h1, SRC_USER, 5'h07, 6'h08, 16'h0009);
		chk_err(ERR_NONE);
		attr(7'h00, 16'hffff);
		acc(1'h1, SRC_ROUTE, 5'h07, 6'h09, 16'h0003);
		acc(1'h0, SRC_USER, 5'h07, 6'h09, 16'h0000);
		chk("rdata", got_rd, 16'h0003);
		acc(1'h1, SRC_DRIVE, 5'h07, 6'h09, 16'h0004);
		chk_err(ERR_READ_ONLY);
		attr(A_RA, 16'hffff);
		acc(1'h1, SRC_USER, 5'h07, 6'h05, 16'h00aa);
		attr(A_SPD, 16'hffff);
		acc(1'h1, SRC_USER, 5'h07, 6'h06, 16'h0077);
		attr(7'h00, 16'hffff);
		acc(1'h0, SRC_USER, 5'h07, 6'h05, 16'h0000);
		chk("rdata", got_rd, 16'h0000);
		trig(2);
		acc(1'h0, SRC_USER, 5'h07, 6'h05, 16'h0000);
		chk("rdata", got_rd, 16'h00aa);
		{nv_d71, nv_d76} = 32'hxxxxxxxx;
		nv_cnt = 0;
		trig(1);
		chk("nv 7.06", nv_d76, 16'h0077);
		chk("nv count", nv_cnt[15:0], 16'h0001);
		nv_last = -1;
		trig(0);
		chk("nv 7.01", nv_d71, 16'h1234);
		chk("nv order", nv_bad[15:0], 16'h0000);
		// a second reset in mid-run clears every value, saved ones included
		@(negedge clk_in);
		rst_n_in = 1'h0;
		repeat (3) @(negedge clk_in);
		rst_n_in = 1'h1;
		wait_idle();
		acc(1'h0, SRC_USER, 5'h07, 6'h01, 16'h0000);
		chk("rdata", got_rd, 16'h0000);
		print_verdict();
	end
endmodule : drive_parameter_store_tb_top
`default_nettype wire
